// ==== rtl/ecc_defs.svh ====
`ifndef ECC_DEFS_SVH
`define ECC_DEFS_SVH
// master source codes
`define ECC_SRC_AUX 3'h1
`define ECC_SRC_PULSE 3'h2
`define ECC_SRC_TIME 3'h4
// engage condition codes
`define ECC_ENG_IMMEDIATE 4'h0
`define ECC_ENG_INPUT 4'h1
// disengage condition codes (low three bits)
`define ECC_DIS_NEVER 3'h0
`define ECC_DIS_INPUT 3'h1
`define ECC_DIS_STOP 3'h2
`define ECC_DIS_LOOP 3'h4
`define ECC_DIS_DECEL 3'h6
// auto disable flag inside disengage condition
`define ECC_DIS_AUTO_OFF_BIT 3
// control word bit positions
`define ECC_CTL_ENABLE_BIT 0
`define ECC_CTL_KEEP_BIT 1
// pulse output source codes
`define ECC_POUT_AUX 2'h1
`define ECC_POUT_IO 2'h2
// time base
`define ECC_TICK_MS 1
`define ECC_CLK_MHZ 200
`define ECC_TICK_CYC (`ECC_TICK_MS * `ECC_CLK_MHZ * 1000)
`endif

// ==== rtl/ecc_pkg.sv ====
package ecc_pkg;
  // clutch states
  typedef enum logic [2:0] {
    ECC_OFF, ECC_LEAD, ECC_WAIT_IN, ECC_ENGAGED, ECC_DECEL, ECC_CMD, ECC_SKIP, ECC_STOPPED
  } ecc_state_t;
  // monitor variables carried together
  typedef struct packed {
    logic signed [31:0] cum_pos;
    logic signed [15:0] per_ms;
    logic signed [31:0] lead_pos;
    logic signed [31:0] cam_pos;
  } ecc_mon_t;
  // configuration fields carried together
  typedef struct packed {
    logic [2:0] source;
    logic [3:0] engage;
    logic [3:0] disengage;
    logic [5:0] cmd_index;
  } ecc_cfg_t;
endpackage

// ==== rtl/ecc_area.sv ====
`timescale 1ns/1ps
`include "ecc_defs.svh"
// one cam-area output; window may wrap around the cycle end
module ecc_area #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic gate,
  input wire logic [W-1:0] angle,
  input wire logic [W-1:0] rise,
  input wire logic [W-1:0] fall,
  output logic out_q
);
  logic in_win; // angle between rise and fall
  // wrap handling: rise above fall means window crosses zero
  always_comb begin
    if (rise <= fall) begin
      in_win = (angle >= rise) && (angle < fall);
    end else begin
      in_win = (angle >= rise) || (angle < fall);
    end
  end
  // registered output gated by the gate input
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= gate & in_win;
    end
  end
endmodule // ecc_area

// ==== rtl/ecc_clutch.sv ====
`timescale 1ns/1ps
`include "ecc_defs.svh"
module ecc_clutch
  import ecc_pkg::*;
#(
  parameter int W = 32,
  parameter int TICK_CYC = `ECC_TICK_CYC,
  parameter int CYCLE_LEN = 36000
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [3:0] CAM_CONTROL_WORD,
  input wire ecc_pkg::ecc_cfg_t CFG,
  input wire logic [W-1:0] LEAD_PULSE_COUNT,
  input wire logic [W-1:0] DISENGAGE_MASTER_COUNT,
  input wire logic [W-1:0] SKIP_PULSE_COUNT,
  input wire logic [W-1:0] AREA1_RISE_ANGLE,
  input wire logic [W-1:0] AREA1_FALL_ANGLE,
  input wire logic [W-1:0] AREA2_RISE_ANGLE,
  input wire logic [W-1:0] AREA2_FALL_ANGLE,
  input wire logic [1:0] PULSE_OUT_SOURCE,
  input wire logic AUX_STEP,
  input wire logic AUX_DIR,
  input wire logic PULSE_STEP,
  input wire logic PULSE_DIR,
  input wire logic CAM_ENGAGE_INPUT,
  input wire logic SERVO_ON,
  input wire logic CMD_DONE,
  output logic SLAVE_STEP,
  output logic SLAVE_DIR,
  output logic DECEL_REQ,
  output logic CMD_START,
  output logic [5:0] CMD_INDEX,
  output logic ENABLE_CLEAR,
  output logic CLUTCH_ENGAGED,
  output logic CAM_AREA_OUTPUT_ONE,
  output logic CAM_AREA_OUTPUT_TWO,
  output logic PULSE_OUT_STEP,
  output logic PULSE_OUT_DIR,
  output logic [1:0] STATE,
  output ecc_pkg::ecc_mon_t MONITOR
);
  ecc_state_t state_q, state_d; // clutch state
  ecc_cfg_t cfg_q; // settings latched while disabled
  logic [W-1:0] lead_q, disc_q, skip_q; // latched counts
  logic enable_q; // cam function active
  logic cam_in_q; // previous engage input level
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_q; // 1 ms divider
  logic tick; // 1 ms enable pulse
  logic m_step, m_dir; // selected master pulse
  logic signed [W-1:0] inc; // signed master increment
  logic signed [W-1:0] eng_cnt_q; // pulses since engagement
  logic [W-1:0] wait_cnt_q; // pulses in lead or skip
  logic signed [W-1:0] cum_q, lead_pos_q, cam_pos_q; // monitors
  logic signed [15:0] ms_acc_q, per_ms_q; // per-ms count
  logic first_q; // no engagement yet since enable
  logic dis_hit; // disengage count reached
  logic cmd_nz; // stored command index nonzero
  logic en_req; // enable requested by control word
  logic keep_q, keep_drop; // servo-off handling
  logic [1:0] src_dummy; // pulse-out source select

  assign en_req = CAM_CONTROL_WORD[`ECC_CTL_ENABLE_BIT];
  assign cmd_nz = (cfg_q.cmd_index != 6'h00);
  assign src_dummy = PULSE_OUT_SOURCE;
  // servo stop drops clutch unless keep bit set
  // keep on servo off
  assign keep_drop = !SERVO_ON && !keep_q;

  // divider producing one-cycle 1 ms tick
  always_ff @(posedge REF_CLK) begin
    if (RESET || tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end
  assign tick = (tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  always_comb begin
    unique case (cfg_q.source)
      `ECC_SRC_AUX: begin
        m_step = AUX_STEP;
        m_dir = AUX_DIR;
      end
      `ECC_SRC_PULSE: begin
        m_step = PULSE_STEP;
        m_dir = PULSE_DIR;
      end
      `ECC_SRC_TIME: begin
        m_step = tick;
        m_dir = 1'b0;
      end
      default: begin
        m_step = 1'b0;
        m_dir = 1'b0;
      end
    endcase
  end
  // dir high counts down
  assign inc = m_step ? (m_dir ? -W'(1) : W'(1)) : '0;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cfg_q <= '0;
      lead_q <= '0;
      disc_q <= '0;
      skip_q <= '0;
      keep_q <= 1'b0;
    end else if (!enable_q) begin
      cfg_q <= CFG;
      lead_q <= LEAD_PULSE_COUNT;
      disc_q <= DISENGAGE_MASTER_COUNT;
      skip_q <= SKIP_PULSE_COUNT;
      keep_q <= CAM_CONTROL_WORD[`ECC_CTL_KEEP_BIT];
    end
  end

  // enable follows control word; auto clear forces it low
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      enable_q <= 1'b0;
    end else if (ENABLE_CLEAR) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= en_req;
    end
  end

  // signed compare by sign of setting
  assign dis_hit = $signed(disc_q) < 0 ? (eng_cnt_q + inc) <= $signed(disc_q)
                                       : (eng_cnt_q + inc) >= $signed(disc_q);

  // engagement from enable, servo or keep bit, condition and counts
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ECC_OFF: begin
        if (enable_q && !keep_drop) begin
          state_d = ECC_LEAD;
        end
      end
      ECC_LEAD: begin
        if (wait_cnt_q >= lead_q) begin
          state_d = (cfg_q.engage == `ECC_ENG_INPUT) ? ECC_WAIT_IN : ECC_ENGAGED;
        end
      end
      ECC_WAIT_IN: begin
        if (CAM_ENGAGE_INPUT && !cam_in_q) begin
          state_d = ECC_ENGAGED;
        end
      end
      ECC_ENGAGED: begin
        unique case (cfg_q.disengage[2:0])
          `ECC_DIS_NEVER: state_d = ECC_ENGAGED;
          `ECC_DIS_INPUT: if (!CAM_ENGAGE_INPUT) state_d = ECC_STOPPED;
          `ECC_DIS_STOP: if (dis_hit) state_d = ECC_STOPPED;
          `ECC_DIS_DECEL: if (dis_hit) state_d = ECC_DECEL;
          `ECC_DIS_LOOP: if (dis_hit) state_d = ECC_CMD;
          default: state_d = ECC_ENGAGED;
        endcase
      end
      ECC_DECEL: state_d = ECC_STOPPED;
      ECC_CMD: begin
        if (!cmd_nz || CMD_DONE) begin
          state_d = ECC_SKIP;
        end
      end
      ECC_SKIP: begin
        if (wait_cnt_q >= skip_q) begin
          state_d = ECC_ENGAGED;
        end
      end
      ECC_STOPPED: begin
        // re-arm input mode when input returns on
        if (cfg_q.disengage[2:0] == `ECC_DIS_INPUT && CAM_ENGAGE_INPUT && !cam_in_q) begin
          state_d = ECC_ENGAGED;
        end
      end
    endcase
    if (!enable_q || (keep_drop && state_q != ECC_OFF)) begin
      state_d = ECC_OFF;
    end
  end

  // state register and engage-input history
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_q <= ECC_OFF;
      cam_in_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cam_in_q <= CAM_ENGAGE_INPUT;
    end
  end

  // lead/skip counter restarts on entering a wait state
  always_ff @(posedge REF_CLK) begin
    if (RESET || (state_d != state_q)) begin
      wait_cnt_q <= '0;
    end else if (m_step) begin
      wait_cnt_q <= wait_cnt_q + 1'b1;
    end
  end

  // engaged pulse count clears when a cycle starts
  always_ff @(posedge REF_CLK) begin
    if (RESET || (state_d == ECC_ENGAGED && state_q != ECC_ENGAGED)) begin
      eng_cnt_q <= '0;
    end else if (state_q == ECC_ENGAGED) begin
      eng_cnt_q <= eng_cnt_q + inc;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      SLAVE_STEP <= 1'b0;
      SLAVE_DIR <= 1'b0;
      CLUTCH_ENGAGED <= 1'b0;
      DECEL_REQ <= 1'b0;
      STATE <= 2'h0;
    end else begin
      SLAVE_STEP <= (state_q == ECC_ENGAGED) && m_step;
      SLAVE_DIR <= m_dir;
      CLUTCH_ENGAGED <= (state_d == ECC_ENGAGED);
      DECEL_REQ <= (state_d == ECC_DECEL);
      STATE <= {(state_d == ECC_STOPPED), (state_d == ECC_ENGAGED)};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CMD_START <= 1'b0;
      CMD_INDEX <= 6'h00;
    end else begin
      CMD_START <= cmd_nz && state_q == ECC_ENGAGED &&
                   (state_d == ECC_STOPPED || state_d == ECC_DECEL || state_d == ECC_CMD) &&
                   cfg_q.disengage[2:0] != `ECC_DIS_INPUT;
      CMD_INDEX <= cfg_q.cmd_index;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ENABLE_CLEAR <= 1'b0;
    end else begin
      ENABLE_CLEAR <= cfg_q.disengage[`ECC_DIS_AUTO_OFF_BIT] &&
                      cfg_q.disengage[2:0] != `ECC_DIS_LOOP &&
                      state_q != ECC_STOPPED && state_d == ECC_STOPPED && !ENABLE_CLEAR;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cum_q <= '0;
      ms_acc_q <= '0;
      per_ms_q <= '0;
    end else begin
      cum_q <= cum_q + inc;
      if (tick) begin
        per_ms_q <= ms_acc_q + inc[15:0];
        ms_acc_q <= '0;
      end else begin
        ms_acc_q <= ms_acc_q + inc[15:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      lead_pos_q <= '0;
      cam_pos_q <= '0;
      first_q <= 1'b1;
    end else if (state_q == ECC_OFF) begin
      lead_pos_q <= '0;
      first_q <= 1'b1;
    end else begin
      if (first_q && state_q != ECC_ENGAGED) begin
        lead_pos_q <= lead_pos_q + inc;
      end
      if (state_q == ECC_ENGAGED) begin
        first_q <= 1'b0;
        if (cam_pos_q + inc >= W'(CYCLE_LEN)) begin
          cam_pos_q <= cam_pos_q + inc - W'(CYCLE_LEN);
        end else if (cam_pos_q + inc < 0) begin
          cam_pos_q <= cam_pos_q + inc + W'(CYCLE_LEN);
        end else begin
          cam_pos_q <= cam_pos_q + inc;
        end
      end
    end
  end

  // monitor output register
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      MONITOR <= '0;
    end else begin
      MONITOR <= '{cum_pos: cum_q, per_ms: per_ms_q, lead_pos: lead_pos_q, cam_pos: cam_pos_q};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PULSE_OUT_STEP <= 1'b0;
      PULSE_OUT_DIR <= 1'b0;
    end else begin
      PULSE_OUT_STEP <= (src_dummy == `ECC_POUT_AUX) ? AUX_STEP :
                        (src_dummy == `ECC_POUT_IO) ? PULSE_STEP : 1'b0;
      PULSE_OUT_DIR <= (src_dummy == `ECC_POUT_AUX) ? AUX_DIR : PULSE_DIR;
    end
  end

  ecc_area #(.W(W)) u_area1 (
    .clk(REF_CLK),
    .rst(RESET),
    .gate(1'b1),
    .angle(cam_pos_q),
    .rise(AREA1_RISE_ANGLE),
    .fall(AREA1_FALL_ANGLE),
    .out_q(CAM_AREA_OUTPUT_ONE)
  );
  ecc_area #(.W(W)) u_area2 (
    .clk(REF_CLK),
    .rst(RESET),
    .gate(state_d == ECC_ENGAGED),
    .angle(cam_pos_q),
    .rise(AREA2_RISE_ANGLE),
    .fall(AREA2_FALL_ANGLE),
    .out_q(CAM_AREA_OUTPUT_TWO)
  );
endmodule // ecc_clutch

// ==== dv/ecc_clutch_monitor.sv ====
`timescale 1ns/1ps
// watches the clutch block from its ports only
module ecc_clutch_monitor (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [3:0] CAM_CONTROL_WORD,
  input wire logic [1:0] PULSE_OUT_SOURCE,
  input wire logic AUX_STEP,
  input wire logic AUX_DIR,
  input wire logic PULSE_STEP,
  input wire logic PULSE_DIR,
  input wire logic SLAVE_STEP,
  input wire logic DECEL_REQ,
  input wire logic CMD_START,
  input wire logic [5:0] CMD_INDEX,
  input wire logic ENABLE_CLEAR,
  input wire logic CLUTCH_ENGAGED,
  input wire logic CAM_AREA_OUTPUT_TWO,
  input wire logic PULSE_OUT_STEP,
  input wire logic PULSE_OUT_DIR
);
  // one clock domain, so clocking and reset are declared once
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // two cycles of slack cover the last step launched as the clutch opens
  a_slave_needs_clutch: assert property (
    SLAVE_STEP |-> $past(CLUTCH_ENGAGED) || $past(CLUTCH_ENGAGED, 2))
    else $error("slave step while clutch open");
  // area two and the engaged flag come from the same next state, so no slack
  a_area_two_gated: assert property (
    !CLUTCH_ENGAGED |-> !CAM_AREA_OUTPUT_TWO)
    else $error("area two output on while disengaged");
  a_pout_aux_copy: assert property (
    PULSE_OUT_SOURCE == 2'h1 && $stable(PULSE_OUT_SOURCE) && AUX_STEP
    |=> PULSE_OUT_STEP && PULSE_OUT_DIR == $past(AUX_DIR)) else $error("aux pulse not repeated");
  a_pout_io_copy: assert property (
    PULSE_OUT_SOURCE == 2'h2 && $stable(PULSE_OUT_SOURCE) && PULSE_STEP
    |=> PULSE_OUT_STEP && PULSE_OUT_DIR == $past(PULSE_DIR)) else $error("io pulse not repeated");
  a_cmd_after_open: assert property (
    CMD_START |-> CMD_INDEX != 6'h00 && !CLUTCH_ENGAGED)
    else $error("command launched with zero index or closed clutch");
  a_decel_once: assert property (DECEL_REQ |-> !CLUTCH_ENGAGED ##1 !DECEL_REQ)
    else $error("decel request malformed");
  a_clear_when_open: assert property (ENABLE_CLEAR |-> !CLUTCH_ENGAGED)
    else $error("enable cleared while engaged");
  a_disable_opens: assert property (!CAM_CONTROL_WORD[0] [*3] |-> !CLUTCH_ENGAGED)
    else $error("clutch held with function disabled");
  // enable is registered, so the word seen two edges back is what opened the way
  a_engage_needs_on: assert property ($rose(CLUTCH_ENGAGED) |-> $past(CAM_CONTROL_WORD[0], 2))
    else $error("engaged without enable");

  c_cmd: cover property (CMD_START);
  c_decel: cover property (DECEL_REQ);
  c_engage: cover property ($rose(CLUTCH_ENGAGED));
endmodule // ecc_clutch_monitor

// ==== dv/ecc_master_model.sv ====
`timescale 1ns/1ps
// master pulse source standing in for an encoder or another drive
module ecc_master_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic dn,
  input wire logic slow,
  output logic step,
  output logic dir,
  output logic busy
);
  logic [7:0] left_q; // pulses still to send
  logic [1:0] gap_q; // spacing for the slow rate
  initial begin
    step = 1'h0;
    dir = 1'h0;
    left_q = 8'h00;
    gap_q = 2'h0;
  end
  assign busy = left_q != 8'h00 || step;
  // one-cycle pulses; direction wanders when idle so nothing leans on a stale level
  always @(posedge clk) begin
    gap_q <= gap_q + 2'h1;
    step <= 1'h0;
    if (go) begin
      left_q <= n;
      dir <= dn;
    end else if (left_q != 8'h00) begin
      if (!slow || gap_q == 2'h0) begin
        step <= 1'h1;
        left_q <= left_q - 8'h01;
      end
    end else begin
      dir <= ~dir;
    end
  end
endmodule // ecc_master_model

// ==== dv/tb_electronic_cam_clutch.sv ====
`timescale 1ns/1ps
module tb_electronic_cam_clutch;
  import ecc_pkg::*;
  logic clk, rst, cam_in, servo, done, go_a, go_p, slow, ba, bp;
  logic a_step, a_dir, p_step, p_dir, s_step, s_dir, decel, cstart, eclr;
  logic eng, area1, area2, po_step, po_dir, dn_a, last_sdir, dec_q;
  logic [3:0] ctl;
  logic [1:0] pout, st, dec_st;
  logic [7:0] nm;
  logic [5:0] cidx, last_idx;
  logic [31:0] lead, dcnt, skip, a1r, a1f, a2r, a2f;
  ecc_cfg_t cfg;
  ecc_mon_t mon;
  int err_count, n_tests, n_slave, n_pout, n_cmd, n_dec, n_clr, b, c, d, e;

  always #2.5 clk = ~clk;

  // short time base keeps the 1 ms source quick to observe
  ecc_clutch #(.TICK_CYC(10)) dut (.REF_CLK(clk), .RESET(rst), .CAM_CONTROL_WORD(ctl),
    .CFG(cfg), .LEAD_PULSE_COUNT(lead), .DISENGAGE_MASTER_COUNT(dcnt),
    .SKIP_PULSE_COUNT(skip), .AREA1_RISE_ANGLE(a1r), .AREA1_FALL_ANGLE(a1f),
    .AREA2_RISE_ANGLE(a2r), .AREA2_FALL_ANGLE(a2f), .PULSE_OUT_SOURCE(pout),
    .AUX_STEP(a_step), .AUX_DIR(a_dir), .PULSE_STEP(p_step), .PULSE_DIR(p_dir),
    .CAM_ENGAGE_INPUT(cam_in), .SERVO_ON(servo), .CMD_DONE(done), .SLAVE_STEP(s_step),
    .SLAVE_DIR(s_dir), .DECEL_REQ(decel), .CMD_START(cstart), .CMD_INDEX(cidx),
    .ENABLE_CLEAR(eclr), .CLUTCH_ENGAGED(eng), .CAM_AREA_OUTPUT_ONE(area1),
    .CAM_AREA_OUTPUT_TWO(area2), .PULSE_OUT_STEP(po_step), .PULSE_OUT_DIR(po_dir),
    .STATE(st), .MONITOR(mon));
  ecc_master_model aux_src (.clk(clk), .go(go_a), .n(nm), .dn(dn_a), .slow(slow),
    .step(a_step), .dir(a_dir), .busy(ba));
  ecc_master_model io_src (.clk(clk), .go(go_p), .n(nm), .dn(1'h0), .slow(slow),
    .step(p_step), .dir(p_dir), .busy(bp));

  // event tallies; the enable is dropped as soon as the block asks for it
  always @(posedge clk) begin
    n_slave <= n_slave + int'(s_step);
    n_pout <= n_pout + int'(po_step);
    n_dec <= n_dec + int'(decel);
    n_clr <= n_clr + int'(eclr);
    // direction of the latest slave step
    if (s_step) last_sdir <= s_dir;
    // state one cycle after a decel request, before auto clear drops it
    dec_q <= decel;
    if (dec_q) dec_st <= st;
    if (cstart) begin
      n_cmd <= n_cmd + 1;
      last_idx <= cidx;
    end
    if (eclr) ctl <= 4'h0;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for the clutch to reach a level
  task automatic wait_eng(input logic v);
    int k;
    k = 0;
    while (eng !== v && k < 50) begin
      @(posedge clk);
      k++;
    end
    chk(eng, v);
    if (eng !== v) summarize();
  endtask

  // one burst of master pulses from aux (0) or io (1)
  task automatic burst(input logic sel, input logic [7:0] n);
    int k;
    go_a <= !sel;
    go_p <= sel;
    nm <= n;
    tick(1);
    go_a <= 1'h0;
    go_p <= 1'h0;
    tick(1);
    k = 0;
    while ((ba || bp) && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) begin
      err_count++;
      $display("Error at %0t: master model never went idle", $time);
      summarize();
    end
    tick(3);
  endtask

  // settings only land while disabled, so drop the enable first
  task automatic arm(input logic [2:0] s, input logic [3:0] en, input logic [3:0] di,
      input logic [5:0] ix, input logic kp);
    ctl <= 4'h0;
    tick(3);
    cfg <= '{source: s, engage: en, disengage: di, cmd_index: ix};
    tick(3);
    ctl <= {2'h0, kp, 1'h1};
    tick(1);
  endtask

  initial begin
    {clk, cam_in, done, go_a, go_p, slow, dn_a, ctl, pout, nm, lead, dcnt, skip} = '0;
    {a1r, a2r} = '0;
    a1f = 32'h64;
    a2f = 32'h64;
    {rst, servo} = 2'h3;
    cfg = '0;
    {err_count, n_tests, n_slave, n_pout, n_cmd, n_dec, n_clr} = '0;
    last_idx = 6'h00;
    tick(2);
    rst <= 1'h0;
    pout <= 2'h1;
    arm(3'h1, 4'h0, 4'h0, 6'h00, 1'h0);
    wait_eng(1'h1);
    b = n_slave;
    c = n_pout;
    burst(1'h0, 8'h05);
    chk(n_slave - b, 32'h5);
    chk(n_pout - c, 32'h5);
    chk(mon.cum_pos, 32'h5);
    chk({area1, area2}, 32'h3);
    chk(mon.cam_pos, 32'h5);
    dn_a <= 1'h1;
    burst(1'h0, 8'h02);
    dn_a <= 1'h0;
    chk(last_sdir, 32'h1);
    chk(mon.cum_pos, 32'h3);
    chk(mon.cam_pos, 32'h3);
    // area one wraps past zero and misses 3, area two spans it
    a1r <= 32'h4;
    a1f <= 32'h2;
    a2r <= 32'h2;
    a2f <= 32'h4;
    tick(2);
    chk({area1, area2}, 32'h1);
    ctl <= 4'h0;
    wait_eng(1'h0);
    tick(2);
    chk(area2, 32'h0);
    $display("test immediate done");
    slow <= 1'h1;
    pout <= 2'h2;
    lead <= 32'h3;
    arm(3'h2, 4'h0, 4'h0, 6'h00, 1'h0);
    b = n_slave;
    c = n_pout;
    burst(1'h1, 8'h02);
    chk(eng, 32'h0);
    burst(1'h1, 8'h01);
    wait_eng(1'h1);
    chk(n_slave - b, 32'h0);
    chk(mon.lead_pos, 32'h3);
    chk(n_pout - c, 32'h3);
    lead <= 32'h0;
    $display("test lead done");
    arm(3'h4, 4'h1, 4'h1, 6'h00, 1'h0);
    tick(30);
    chk(eng, 32'h0);
    cam_in <= 1'h1;
    wait_eng(1'h1);
    b = n_slave;
    tick(60);
    chk(n_slave > b, 32'h1);
    chk(mon.per_ms, 32'h1);
    cam_in <= 1'h0;
    wait_eng(1'h0);
    tick(2);
    b = n_slave;
    tick(60);
    chk(n_slave - b, 32'h0);
    $display("test input done");
    dcnt <= 32'h4;
    arm(3'h1, 4'h0, 4'h2, 6'h05, 1'h0);
    wait_eng(1'h1);
    b = n_slave;
    c = n_cmd;
    burst(1'h0, 8'h06);
    chk(eng, 32'h0);
    chk(n_slave - b, 32'h4);
    chk(st, 32'h2);
    chk(n_cmd - c, 32'h1);
    chk(last_idx, 32'h5);
    $display("test stop done");
    arm(3'h1, 4'h0, 4'hE, 6'h00, 1'h0);
    wait_eng(1'h1);
    c = n_cmd;
    d = n_dec;
    e = n_clr;
    burst(1'h0, 8'h06);
    chk(n_dec - d, 32'h1);
    chk(dec_st, 32'h2);
    chk(n_clr - e, 32'h1);
    chk(n_cmd - c, 32'h0);
    $display("test decel done");
    skip <= 32'h2;
    arm(3'h1, 4'h0, 4'h4, 6'h03, 1'h0);
    wait_eng(1'h1);
    burst(1'h0, 8'h04);
    chk(eng, 32'h0);
    burst(1'h0, 8'h03);
    chk(eng, 32'h0);
    done <= 1'h1;
    burst(1'h0, 8'h02);
    wait_eng(1'h1);
    done <= 1'h0;
    $display("test loop done");
    arm(3'h1, 4'h0, 4'h0, 6'h00, 1'h1);
    wait_eng(1'h1);
    servo <= 1'h0;
    tick(5);
    chk(eng, 32'h1);
    servo <= 1'h1;
    arm(3'h1, 4'h0, 4'h0, 6'h00, 1'h0);
    wait_eng(1'h1);
    servo <= 1'h0;
    wait_eng(1'h0);
    $display("test servo done");
    summarize();
  end
endmodule // tb_electronic_cam_clutch

bind ecc_clutch ecc_clutch_monitor mon_i (.REF_CLK(REF_CLK), .RESET(RESET),
  .CAM_CONTROL_WORD(CAM_CONTROL_WORD), .PULSE_OUT_SOURCE(PULSE_OUT_SOURCE),
  .AUX_STEP(AUX_STEP), .AUX_DIR(AUX_DIR), .PULSE_STEP(PULSE_STEP), .PULSE_DIR(PULSE_DIR),
  .SLAVE_STEP(SLAVE_STEP), .DECEL_REQ(DECEL_REQ), .CMD_START(CMD_START),
  .CMD_INDEX(CMD_INDEX), .ENABLE_CLEAR(ENABLE_CLEAR), .CLUTCH_ENGAGED(CLUTCH_ENGAGED),
  .CAM_AREA_OUTPUT_TWO(CAM_AREA_OUTPUT_TWO), .PULSE_OUT_STEP(PULSE_OUT_STEP),
  .PULSE_OUT_DIR(PULSE_OUT_DIR));
